// ### inc/swd_pkg.sv
// constants for the software watchdog timer
package swd_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned CLK_PERIOD_NS   = 1000000000 / CLK_HZ;
  localparam int unsigned TIMEOUT_CYCLES  = 131072;
  localparam int unsigned STAB_CYCLES     = 4064;
  localparam int unsigned CNT_W           = 17;
  localparam int unsigned STAB_W          = 12;
  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES - 1);
  localparam logic [CNT_W-1:0] STAB_COUNT = CNT_W'(STAB_CYCLES);

  // register indices; byte address is four times the index
  localparam logic [15:0] CLEAR_REG_IDX   = 16'h1ff0;
  localparam logic [15:0] STATUS_REG_IDX  = 16'h1ff1;
  localparam logic [15:0] CLEAR_REG_ADDR  = 16'h7fc0;
  localparam logic [15:0] STATUS_REG_ADDR = 16'h7fc4;

  // field positions and reset values
  localparam int unsigned CLEAR_BIT_POS   = 0;
  localparam logic CLEAR_BIT_RST          = 1'b0;
  localparam logic [CNT_W-1:0] CNT_RST    = 17'h00000;
  localparam logic [31:0] UNMAPPED_RDATA  = 32'h00000000;

  typedef enum logic [2:0] {
    SWD_RUN,
    SWD_STOP,
    SWD_HALT,
    SWD_STAB_RST,
    SWD_STAB_INT
  } swd_state_e;
endpackage

// ### verification/swd_top_test.sv
// self-checking bench for the software watchdog timer
`timescale 1ns/1ps
module swd_top_test;
  localparam int unsigned TMO = 5000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  nvm_data = 8'ha5;
  logic        stop_exec = 1'b0;
  logic        irq_wake_n = 1'b1;
  logic        reset_req;
  logic [16:0] wdt_count;
  logic        clock_stopped;
  logic        h_stopped;
  logic [16:0] h_count;
  logic        a_req;
  int          nabs = 0;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          nreq = 0;
  int          n;
  int          k;
  logic [31:0] q;
  logic [16:0] h1;

  always #10 clk = ~clk;

  swd_top #(.TIMEOUT_CYCLES(17'(TMO))) u_swd_top (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nvm_data(nvm_data), .stop_exec(stop_exec), .irq_wake_n(irq_wake_n),
    .reset_req(reset_req), .wdt_count(wdt_count), .clock_stopped(clock_stopped));

  // stop-disable option: stop enters halt and counting goes on
  swd_top #(.TIMEOUT_CYCLES(17'(TMO)), .STOP_DISABLE(1'b1)) u_swd_top_halt (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(1'b0), .avs_write(1'b0),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .nvm_data(nvm_data), .stop_exec(stop_exec), .irq_wake_n(1'b1),
    .reset_req(), .wdt_count(h_count), .clock_stopped(h_stopped));

  // absent option: never requests a reset
  swd_top #(.TIMEOUT_CYCLES(17'(TMO)), .WDT_PRESENT(1'b0)) u_swd_top_absent (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(1'b0), .avs_write(1'b0),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .nvm_data(nvm_data), .stop_exec(stop_exec), .irq_wake_n(irq_wake_n),
    .reset_req(a_req), .wdt_count(), .clock_stopped());

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; returns at the accept edge with read data in q
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    int w;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (avs_waitrequest !== 1'b0 && w < 50);
    if (w >= 50) check(32'h1, 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic count_in(input int lo, input int hi);
    bus(1'b0, swd_pkg::STATUS_REG_ADDR, 32'h0, 4'hf);
    check({31'h0, q[16:0] >= 17'(lo) && q[16:0] <= 17'(hi)}, 32'h1);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 80000) begin
      err_total++;
      stop_test();
    end
  end

  always @(negedge clk) begin
    if (reset_req === 1'b1) nreq++;
    if (a_req !== 1'b0) nabs++;
  end

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    check({29'h0, reset_req, clock_stopped, wdt_count == 17'h0}, 32'h1);
    @(posedge clk);
    rst <= 1'b0;
    idle(4100);
    bus(1'b0, swd_pkg::CLEAR_REG_ADDR, 32'h0, 4'hf);
    check(q, 32'h000000a5);
    bus(1'b0, 16'h0100, 32'h0, 4'hf);
    check(q, swd_pkg::UNMAPPED_RDATA);
    bus(1'b1, swd_pkg::CLEAR_REG_ADDR, 32'h0, 4'hf);
    count_in(0, 3);
    idle(200);
    bus(1'b1, swd_pkg::CLEAR_REG_ADDR, 32'h1, 4'hf);
    bus(1'b1, swd_pkg::CLEAR_REG_ADDR, 32'h0, 4'he);
    bus(1'b1, swd_pkg::STATUS_REG_ADDR, 32'h0, 4'hf);
    count_in(200, 230);
    bus(1'b1, swd_pkg::CLEAR_REG_ADDR, 32'h0, 4'hf);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (reset_req !== 1'b1 && n < TMO + 100);
    // request rises TMO edges after the accept edge and is first seen at the negedge after it
    check(n, TMO + 1);
    check({15'h0, wdt_count}, 32'h0);
    @(negedge clk);
    check({31'h0, reset_req}, 32'h0);
    k = nreq;
    for (int i = 0; i < 3; i++) begin
      idle(TMO - 1000);
      bus(1'b1, swd_pkg::CLEAR_REG_ADDR, 32'h0, 4'hf);
    end
    check(nreq, k);
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    @(negedge clk);
    check({30'h0, clock_stopped, wdt_count == 17'h0}, 32'h3);
    h1 = h_count;
    idle(100);
    @(negedge clk);
    check({15'h0, wdt_count}, 32'h0);
    check({30'h0, h_stopped, h_count != h1}, 32'h1);
    @(posedge clk);
    irq_wake_n <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (clock_stopped !== 1'b0 && n < 20);
    check({31'h0, n < 20}, 32'h1);
    @(posedge clk);
    irq_wake_n <= 1'b1;
    idle(4100);
    count_in(4095, 4115);
    @(posedge clk);
    rst <= 1'b1;
    idle(3);
    @(negedge clk);
    check({15'h0, wdt_count}, 32'h0);
    check({15'h0, h_count}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    idle(4100);
    count_in(30, 45);
    check(nabs, 0);
    stop_test();
  end
endmodule

// ### verilog/swd_top.sv
// software watchdog timer with avalon-mm slave and low-power mode handling
//
// Overview of operation
// - 17-bit counter requests reset when expired
// - timeout is 131,072 bus clock cycles
// - writing zero to clear bit restarts period
// - clear register reads back nonvolatile memory
// - no interrupt, only reset request
// - any reset clears the clear bit
// - counting only on internal clock
// - stop instruction clears the counter
// - reset exit: clear again after stabilization
// - interrupt exit: counter holds 4064 at resume
// - stop disabled enters halt, counter runs
// - halt reset exit restarts from zero
// - wait mode counts as normal operation
// - whole function present or absent by option
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module swd_top #(
  parameter logic [16:0] TIMEOUT_CYCLES = 17'(swd_pkg::TIMEOUT_CYCLES),
  parameter bit          STOP_DISABLE   = 1'b0,
  parameter bit          WDT_PRESENT    = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  nvm_data,
  input  wire logic        stop_exec,
  input  wire logic        irq_wake_n,
  output logic             reset_req,
  output logic      [16:0] wdt_count,
  output logic             clock_stopped
);

  localparam logic [16:0] TOP = TIMEOUT_CYCLES - 17'h00001;

  logic                   ack_q;
  logic [31:0]            rdata_q;
  logic                   clear_bit_q;
  logic [16:0]            cnt_q;
  logic [16:0]            cnt_d;
  logic [11:0]            stab_q;
  logic                   reset_req_q;
  logic                   wake_s1_q;
  logic                   wake_s2_q;
  swd_pkg::swd_state_e    state_q;
  swd_pkg::swd_state_e    state_d;

  logic                   req;
  logic                   wr_acc;
  logic                   hit_clear;
  logic                   hit_status;
  logic                   clr_wr;
  logic                   wake;
  logic                   stop_now;
  logic                   halt_now;
  logic                   counting;
  logic                   expire;

  // bus slave: one wait cycle, answer at second edge
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_acc          = avs_write & ack_q;
  assign hit_clear       = (avs_address == swd_pkg::CLEAR_REG_ADDR);
  assign hit_status      = (avs_address == swd_pkg::STATUS_REG_ADDR);
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= swd_pkg::UNMAPPED_RDATA;
    end else if (avs_read & ~ack_q) begin
      if (hit_clear) begin
        rdata_q <= {24'h000000, nvm_data};
      end else if (hit_status) begin
        rdata_q <= {15'h0000, cnt_q};
      end else begin
        rdata_q <= swd_pkg::UNMAPPED_RDATA;
      end
    end
  end

  // clear bit: write-only, zero written restarts the period
  assign clr_wr = wr_acc & hit_clear & avs_byteenable[0] & ~avs_writedata[swd_pkg::CLEAR_BIT_POS];

  always_ff @(posedge clk) begin
    if (rst) begin
      clear_bit_q <= swd_pkg::CLEAR_BIT_RST;
    end else if (wr_acc & hit_clear & avs_byteenable[0]) begin
      clear_bit_q <= avs_writedata[swd_pkg::CLEAR_BIT_POS];
    end
  end

  // wake interrupt pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= ~irq_wake_n;
      wake_s2_q <= wake_s1_q;
    end
  end

  assign wake     = wake_s2_q;
  assign stop_now = (state_q == swd_pkg::SWD_RUN) & stop_exec & ~STOP_DISABLE;
  assign halt_now = (state_q == swd_pkg::SWD_RUN) & stop_exec & STOP_DISABLE;

  // mode sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      swd_pkg::SWD_RUN: begin
        if (stop_now) begin
          state_d = swd_pkg::SWD_STOP;
        end else if (halt_now) begin
          state_d = swd_pkg::SWD_HALT;
        end
      end
      swd_pkg::SWD_STOP: begin
        if (wake) begin
          state_d = swd_pkg::SWD_STAB_INT;
        end
      end
      swd_pkg::SWD_HALT: begin
        if (wake) begin
          state_d = swd_pkg::SWD_RUN;
        end
      end
      swd_pkg::SWD_STAB_RST: begin
        if (stab_q == swd_pkg::STAB_LAST) begin
          state_d = swd_pkg::SWD_RUN;
        end
      end
      swd_pkg::SWD_STAB_INT: begin
        if (stab_q == swd_pkg::STAB_LAST) begin
          state_d = swd_pkg::SWD_RUN;
        end
      end
      default: begin
        state_d = swd_pkg::SWD_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= swd_pkg::SWD_STAB_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // oscillator stabilization delay counter
  always_ff @(posedge clk) begin
    if (rst) begin
      stab_q <= 12'h000;
    end else if ((state_q == swd_pkg::SWD_STAB_RST) || (state_q == swd_pkg::SWD_STAB_INT)) begin
      stab_q <= stab_q + 12'h001;
    end else begin
      stab_q <= 12'h000;
    end
  end

  // run, halt, wait and interrupt stabilization all advance toward expiry
  assign counting = (state_q == swd_pkg::SWD_RUN) | (state_q == swd_pkg::SWD_HALT) |
                    (state_q == swd_pkg::SWD_STAB_INT);
  assign expire   = WDT_PRESENT & counting & (cnt_q == TOP) & ~clr_wr & ~stop_now;

  always_comb begin
    cnt_d = cnt_q + 17'h00001;
    if (!WDT_PRESENT) begin
      cnt_d = swd_pkg::CNT_RST;
    end else begin
      case (state_q)
        swd_pkg::SWD_STOP: begin
          cnt_d = swd_pkg::CNT_RST;
        end
        swd_pkg::SWD_STAB_RST: begin
          if (stab_q == swd_pkg::STAB_LAST) begin
            cnt_d = swd_pkg::CNT_RST;
          end
        end
        default: begin
          if (stop_now) begin
            cnt_d = swd_pkg::CNT_RST;
          end else if (clr_wr) begin
            cnt_d = swd_pkg::CNT_RST;
          end else if (cnt_q == TOP) begin
            cnt_d = swd_pkg::CNT_RST;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= swd_pkg::CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= expire;
    end
  end

  assign reset_req     = reset_req_q;
  assign wdt_count     = cnt_q;
  assign clock_stopped = (state_q == swd_pkg::SWD_STOP);

  // checks
  property p_expire_req;
    @(posedge clk) disable iff (rst)
      (counting && cnt_q == TOP && !clr_wr && !stop_now && WDT_PRESENT) |=> reset_req && cnt_q == 17'h00000;
  endproperty
  a_expire_req: assert property (p_expire_req) else $error("expiry did not request reset");

  property p_req_cause;
    @(posedge clk) disable iff (rst)
      $rose(reset_req) |-> $past(cnt_q) == TOP;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("reset request without expiry");

  property p_clear_zero;
    @(posedge clk) disable iff (rst)
      (clr_wr && state_q != swd_pkg::SWD_STOP && state_q != swd_pkg::SWD_STAB_RST) |=> cnt_q == 17'h00000;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear write did not restart counter");

  property p_one_ignored;
    @(posedge clk) disable iff (rst)
      (wr_acc && hit_clear && avs_writedata[0] && state_q == swd_pkg::SWD_RUN && !stop_now &&
       cnt_q != TOP && WDT_PRESENT) |=> cnt_q == $past(cnt_q) + 17'h00001;
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("writing one disturbed counter");

  property p_read_nvm;
    @(posedge clk) disable iff (rst)
      (avs_read && !ack_q && hit_clear) |=> (avs_readdata == {24'h000000, $past(nvm_data)}) && !avs_waitrequest;
  endproperty
  a_read_nvm: assert property (p_read_nvm) else $error("clear register read not from memory");

  property p_stop_clear;
    @(posedge clk) disable iff (rst)
      stop_now && WDT_PRESENT |=> cnt_q == 17'h00000 && clock_stopped;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear counter");

  property p_stop_hold;
    @(posedge clk) disable iff (rst)
      (clock_stopped && !wake) |=> cnt_q == 17'h00000 && !reset_req;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved with clock stopped");

  property p_stab_rst_end;
    @(posedge clk) disable iff (rst)
      (state_q == swd_pkg::SWD_STAB_RST && stab_q == swd_pkg::STAB_LAST) |=>
        cnt_q == 17'h00000 && state_q == swd_pkg::SWD_RUN;
  endproperty
  a_stab_rst_end: assert property (p_stab_rst_end) else $error("counter not cleared after stabilization");

  property p_stab_int_end;
    @(posedge clk) disable iff (rst)
      (state_q == swd_pkg::SWD_STAB_INT && stab_q == swd_pkg::STAB_LAST && !clr_wr &&
       swd_pkg::STAB_COUNT < TIMEOUT_CYCLES && WDT_PRESENT) |=> cnt_q == swd_pkg::STAB_COUNT;
  endproperty
  a_stab_int_end: assert property (p_stab_int_end) else $error("count not 4064 at resume");

  property p_halt_runs;
    @(posedge clk) disable iff (rst)
      (state_q == swd_pkg::SWD_HALT && !clr_wr && cnt_q != TOP && WDT_PRESENT) |=>
        cnt_q == $past(cnt_q) + 17'h00001;
  endproperty
  a_halt_runs: assert property (p_halt_runs) else $error("counter stalled in halt");

  property p_reset_restart;
    @(posedge clk)
      rst |=> cnt_q == 17'h00000 && clear_bit_q == 1'b0 && state_q == swd_pkg::SWD_STAB_RST;
  endproperty
  a_reset_restart: assert property (p_reset_restart) else $error("reset did not restart watchdog");

  property p_absent;
    @(posedge clk) disable iff (rst)
      !WDT_PRESENT |-> !reset_req;
  endproperty
  a_absent: assert property (p_absent) else $error("absent watchdog requested reset");

endmodule
